// [hdl/playback_gain_supply_control.sv]
// Playback high-pass, polarity, volume, supply switching and noise gate
//
// Overview of operation
// - Three-bit setting picks high-pass corner; zero bypasses the filter.
// - Output normally follows input sign; invert bit flips it.
// - Five-bit amplifier level sets output level; gains add up.
// - Digital volume spans 0 to -100 dB in 0.5 dB steps.
// - Volume codes above C8h mute the output.
// - Volume resets to 0 dB.
// - Volume changes ramp at a rate chosen by a two-bit field.
// - Ramp field 11 applies volume changes at once.
// - Safe mode forces fixed 18 dB attenuation, volume code 24h.
// - In safe mode the volume field is ignored and ramping is off.
// - Level below threshold for hysteresis time moves stage to battery rail.
// - Level above threshold returns stage to the high-voltage supply.
// - Remaining samples are output before bypass is released high.
// - Bypass pulled low and bridge returned after separate two-bit delays.
// - Threshold mode resets relative, relative field resets to 010.
// - Low-power mode uses two-bit threshold, bridge mode the five-bit one.
// - Switching level ignores limiter and thermal attenuation.
// - Supply mode 00 bridge, 10 high voltage only, 11 low-power switching.
// - Outside switching modes the stage stays on the selected supply.
// - In bridge mode, high supply below battery plus 2.5 V holds stage on it.
// - Gate powers stage down after level stays below threshold for gate time.
// - Gate re-powers stage before rising samples reach the bridge.
// - Fine gating uses a 24-bit level and a separate fine hysteresis.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pgsc_map.svh"
module playback_gain_supply_control #(
    parameter int W = 24
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_we,
    input  wire logic             reg_re,
    output logic [31:0]           reg_rdata,
    // Sample stream
    input  wire logic [W-1:0]     sample_in,
    input  wire logic             sample_valid,
    output logic [W-1:0]          sample_out,
    output logic                  sample_out_valid,
    // Analog side
    input  wire logic             hv_below_margin,
    input  wire logic             rel_level_above,
    output logic [4:0]            amp_output_level,
    output logic [3:0]            switch_relative_threshold,
    output logic                  internal_regulator_mode,
    output pgsc_pkg::bridge_supply_t bridge_supply,
    output logic                  stage_power_on,
    // Open-drain bypass enable line
    input  wire logic             bypass_enable_in,
    output logic                  bypass_enable_out,
    output logic                  bypass_enable_oe
);
    import pgsc_pkg::*;

    // ==========================================
    // Registers
    logic [9:0]  ctrl_q;
    logic [12:0] level_q;
    logic [19:0] sw_q;
    logic [6:0]  gate_q;
    logic [23:0] fine_lvl_q;
    logic [15:0] fine_hys_q;
    logic [31:0] rdata_q;
    logic [7:0]  cur_code;

    wire wr_ctrl  = reg_we && reg_addr == `PGSC_ADDR_CTRL;
    wire wr_level = reg_we && reg_addr == `PGSC_ADDR_LEVEL;
    wire wr_sw    = reg_we && reg_addr == `PGSC_ADDR_SWITCH;
    wire wr_gate  = reg_we && reg_addr == `PGSC_ADDR_GATE;
    wire wr_flvl  = reg_we && reg_addr == `PGSC_ADDR_FINE_LVL;
    wire wr_fhys  = reg_we && reg_addr == `PGSC_ADDR_FINE_HYS;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q     <= `CTRL_RESET;
            level_q    <= `LEVEL_RESET;
            sw_q       <= `SWITCH_RESET;
            gate_q     <= `GATE_RESET;
            fine_lvl_q <= '0;
            fine_hys_q <= '0;
        end else begin
            if (wr_ctrl)  ctrl_q     <= reg_wdata[9:0];
            if (wr_level) level_q    <= reg_wdata[12:0];
            if (wr_sw)    sw_q       <= reg_wdata[19:0];
            if (wr_gate)  gate_q     <= reg_wdata[6:0];
            if (wr_flvl)  fine_lvl_q <= reg_wdata[23:0];
            if (wr_fhys)  fine_hys_q <= reg_wdata[15:0];
        end
    end

    // Field views
    wire [2:0]   hpf_sel    = ctrl_q[`CTRL_HPF_SEL];
    wire         invert     = ctrl_q[`CTRL_INVERT];
    wire [1:0]   smode_raw  = ctrl_q[`CTRL_SUPPLY];
    wire [4:0]   fth        = sw_q[`SW_FTH];
    wire [1:0]   fth_low    = sw_q[`SW_FTH_LOW];
    wire [3:0]   hys        = sw_q[`SW_HYS];
    wire [1:0]   byp_dly    = sw_q[`SW_BYP_DLY];
    wire [1:0]   brg_dly    = sw_q[`SW_BRIDGE_DLY];
    wire         tmode      = sw_q[`SW_TMODE];
    supply_mode_t smode;
    assign smode = supply_mode_t'(smode_raw);

    // ==========================================
    // High-pass filter
    logic signed [W+1:0] hx1_q, hy_q;
    logic [W-1:0]        hpf_q, pol_q;
    logic                v1_q, v2_q;

    function automatic logic [W-1:0] sat(input logic signed [W+1:0] x);
        if (x > $signed({3'b000, {(W-1){1'b1}}}))
            sat = {1'b0, {(W-1){1'b1}}};
        else if (x < -$signed({3'b001, {(W-1){1'b0}}}))
            sat = {1'b1, {(W-1){1'b0}}};
        else
            sat = x[W-1:0];
    endfunction

    wire [3:0]           hpf_shift = {1'b0, hpf_sel} + `HPF_SHIFT_BASE;
    wire signed [W+1:0]  hx   = {{2{sample_in[W-1]}}, sample_in};
    wire signed [W+1:0]  hy_d = hx - hx1_q + hy_q - (hy_q >>> hpf_shift);
    wire [W-1:0]         hpf_out = (hpf_sel == 3'b000) ? sample_in : sat(hy_d);
    wire signed [W+1:0]  hpf_ext = {{2{hpf_q[W-1]}}, hpf_q};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hx1_q <= '0;
            hy_q  <= '0;
            hpf_q <= '0;
            pol_q <= '0;
            v1_q  <= 1'b0;
            v2_q  <= 1'b0;
        end else begin
            v1_q <= sample_valid;
            v2_q <= v1_q;
            if (sample_valid) begin
                hx1_q <= hx;
                hy_q  <= (hpf_sel == 3'b000) ? '0 : hy_d;
                hpf_q <= hpf_out;
            end
            if (v1_q) begin
                pol_q <= invert ? sat(-hpf_ext) : hpf_q;
            end
        end
    end

    // ==========================================
    // Digital volume
    pb_volume_stage #(.W(W)) u_volume (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .target_code (level_q[`LEVEL_VOL]),
        .safe        (ctrl_q[`CTRL_SAFE]),
        .ramp_rate   (ctrl_q[`CTRL_RAMP]),
        .din         (pol_q),
        .din_valid   (v2_q),
        .dout        (sample_out),
        .dout_valid  (sample_out_valid),
        .cur_code    (cur_code)
    );

    // ==========================================
    // Supply switching
    localparam logic [W:0] FULL_SCALE = (W+1)'(1) << (W-1);
    switch_state_t st_q, st_d;
    logic [15:0]   cnt_q, cnt_d;
    logic          bat_q, byp_q;

    // Level after volume only; no limiter or thermal gain enters here
    wire [W:0]  out_lvl   = sample_out[W-1] ? (W+1)'(-$signed({sample_out[W-1], sample_out}))
                                            : {1'b0, sample_out};
    wire [4:0]  thr_shift = (smode == MODE_LOWPWR) ? `LOWPWR_THR_SHIFT + {3'b000, fth_low} : fth;
    wire [W:0]  fixed_thr = FULL_SCALE >> thr_shift;
    wire        above     = tmode ? rel_level_above : (out_lvl > fixed_thr);
    wire        allow     = (smode == MODE_BRIDGE && !hv_below_margin) || smode == MODE_LOWPWR;
    wire [15:0] hys_lim   = 16'({12'h000, hys} + 16'd1) * `HYS_UNIT_SAMPLES - 16'd1;
    wire [15:0] byp_lim   = 16'({14'h0000, byp_dly} + 16'd1) * `DLY_UNIT_CYCLES;
    wire [15:0] brg_lim   = 16'({14'h0000, brg_dly} + 16'd1) * `DLY_UNIT_CYCLES;
    wire        rise      = sample_out_valid && above;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        case (st_q)
            ST_HV: begin
                if (allow && sample_out_valid && !above) begin
                    st_d  = ST_HYST;
                    cnt_d = 16'd0;
                end
            end
            ST_HYST: begin
                if (!allow || rise) begin
                    st_d = ST_HV;
                end else if (sample_out_valid) begin
                    if (cnt_q >= hys_lim) begin
                        st_d  = ST_DRAIN;
                        cnt_d = 16'd0;
                    end else begin
                        cnt_d = cnt_q + 16'd1;
                    end
                end
            end
            ST_DRAIN: begin
                if (!allow || rise) begin
                    st_d = ST_HV;
                end else if (sample_out_valid) begin
                    if (cnt_q >= `DRAIN_SAMPLES - 16'd1) begin
                        st_d = ST_BAT;
                    end else begin
                        cnt_d = cnt_q + 16'd1;
                    end
                end
            end
            ST_BAT: begin
                if (!allow || rise) begin
                    st_d  = ST_RETURN;
                    cnt_d = 16'd0;
                end
            end
            ST_RETURN: begin
                cnt_d = cnt_q + 16'd1;
                if (cnt_q >= byp_lim && cnt_q >= brg_lim) begin
                    st_d = ST_HV;
                end
            end
            default: begin
                st_d = ST_HV;
            end
        endcase
    end

    // Shared line must read released before the bridge leaves the high supply
    wire bat_d = allow && ((st_q == ST_BAT && bypass_enable_in) ||
                           (st_q == ST_RETURN && bat_q && cnt_q < brg_lim));
    wire byp_d = st_q == ST_BAT || (st_q == ST_RETURN && cnt_q < byp_lim);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q  <= ST_HV;
            cnt_q <= 16'd0;
            bat_q <= 1'b0;
            byp_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            bat_q <= bat_d;
            byp_q <= byp_d;
        end
    end

    assign bridge_supply     = bat_q ? SUPPLY_BAT : SUPPLY_HV;
    assign bypass_enable_out = 1'b0;
    assign bypass_enable_oe  = !byp_q;

    // ==========================================
    // Noise gate
    logic [15:0] gcnt_q;
    logic        pwr_q;

    wire         gate_en   = gate_q[`GATE_EN];
    wire         fine_en   = gate_q[`GATE_FINE_EN];
    wire [W:0]   in_lvl    = sample_in[W-1] ? (W+1)'(-$signed({sample_in[W-1], sample_in}))
                                            : {1'b0, sample_in};
    wire [26:0]  lvl27     = 27'(in_lvl);
    wire [26:0]  coarse27  = 27'(FULL_SCALE >> (`GATE_THR_SHIFT + {3'b000, gate_q[`GATE_LVL]}));
    wire [26:0]  fine27    = {3'b000, fine_lvl_q};
    wire [26:0]  fopen27   = fine27 + {8'h00, fine_hys_q, 3'b000};
    wire         g_above   = fine_en ? (lvl27 > fopen27) : (lvl27 > coarse27);
    wire         g_below   = fine_en ? (lvl27 < fine27) : !g_above;
    wire [15:0]  gate_lim  = `GATE_UNIT_SAMPLES << gate_q[`GATE_TIME];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gcnt_q <= 16'd0;
            pwr_q  <= 1'b1;
        end else if (!gate_en) begin
            gcnt_q <= 16'd0;
            pwr_q  <= 1'b1;
        end else if (sample_valid && g_above) begin
            gcnt_q <= 16'd0;
            pwr_q  <= 1'b1;
        end else if (sample_valid && g_below && pwr_q) begin
            if (gcnt_q >= gate_lim) begin
                pwr_q <= 1'b0;
            end else begin
                gcnt_q <= gcnt_q + 16'd1;
            end
        end
    end

    assign stage_power_on = pwr_q;

    // ==========================================
    // Register read and plain outputs
    wire [31:0] status = {21'h000000, pwr_q, byp_q, bat_q, cur_code};
    wire [31:0] rd_mux =
        (reg_addr == `PGSC_ADDR_CTRL)     ? {22'h000000, ctrl_q} :
        (reg_addr == `PGSC_ADDR_LEVEL)    ? {19'h00000, level_q} :
        (reg_addr == `PGSC_ADDR_SWITCH)   ? {12'h000, sw_q} :
        (reg_addr == `PGSC_ADDR_GATE)     ? {25'h0000000, gate_q} :
        (reg_addr == `PGSC_ADDR_FINE_LVL) ? {8'h00, fine_lvl_q} :
        (reg_addr == `PGSC_ADDR_FINE_HYS) ? {16'h0000, fine_hys_q} :
        (reg_addr == `PGSC_ADDR_STATUS)   ? status : 32'h00000000;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= reg_re ? rd_mux : 32'h00000000;
        end
    end

    assign reg_rdata                 = rdata_q;
    assign amp_output_level          = level_q[`LEVEL_AMP];
    assign switch_relative_threshold = sw_q[`SW_RTH];
    assign internal_regulator_mode   = ctrl_q[`CTRL_IREG];

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_hpf_bypass_pass: assert property (sample_valid && hpf_sel == 3'b000 |=> hpf_q == $past(sample_in))
        else $error("bypassed filter altered the sample");
    a_polarity_path: assert property (v1_q && !invert && !$past(rst) |=> pol_q == $past(hpf_q))
        else $error("non-inverted path changed the sample");
    a_bypass_after_drain: assert property ($rose(byp_q) |-> $past(st_q) == ST_BAT && $past(st_q, 2) == ST_DRAIN)
        else $error("bypass released before samples drained");
    a_hv_only_hold: assert property (smode == MODE_HV_ONLY |=> bridge_supply == SUPPLY_HV)
        else $error("stage left the high supply in high-only mode");
    a_margin_hold_hv: assert property (smode == MODE_BRIDGE && hv_below_margin |=> bridge_supply == SUPPLY_HV)
        else $error("switched with high supply under margin");
    a_return_on_rise: assert property (st_q == ST_BAT && rise |=> st_q == ST_RETURN)
        else $error("rise above threshold did not start return");
    a_gate_wake_fast: assert property (gate_en && sample_valid && g_above |=> pwr_q ##2 sample_out_valid)
        else $error("gate did not re-power ahead of the samples");
    a_gate_off_only: assert property ($fell(pwr_q) |-> $past(gate_en) && $past(gcnt_q) >= $past(gate_lim))
        else $error("stage powered down before gate time");
endmodule
`default_nettype wire

// [hdl/pgsc_map.svh]
// Register offsets, field positions, reset values and counts of the playback block
`ifndef PGSC_MAP_SVH
`define PGSC_MAP_SVH

// ==========================================
// Register offsets (byte addresses)
`define PGSC_ADDR_CTRL      8'h00
`define PGSC_ADDR_LEVEL     8'h04
`define PGSC_ADDR_SWITCH    8'h08
`define PGSC_ADDR_GATE      8'h0c
`define PGSC_ADDR_FINE_LVL  8'h10
`define PGSC_ADDR_FINE_HYS  8'h14
`define PGSC_ADDR_STATUS    8'h18

// ==========================================
// Field positions
`define CTRL_HPF_SEL        2:0
`define CTRL_INVERT         3
`define CTRL_SAFE           4
`define CTRL_RAMP           6:5
`define CTRL_IREG           7
`define CTRL_SUPPLY         9:8
`define LEVEL_VOL           7:0
`define LEVEL_AMP           12:8
`define SW_FTH              4:0
`define SW_FTH_LOW          6:5
`define SW_HYS              10:7
`define SW_BYP_DLY          12:11
`define SW_BRIDGE_DLY       14:13
`define SW_TMODE            15
`define SW_RTH              19:16
`define GATE_EN             0
`define GATE_LVL            2:1
`define GATE_TIME           5:3
`define GATE_FINE_EN        6

// ==========================================
// Reset values
`define CTRL_RESET          10'h200
`define LEVEL_RESET         13'h0000
`define SWITCH_RESET        20'h28000
`define GATE_RESET          7'h00
`define VOL_RESET           8'h00

// ==========================================
// Volume and timing counts
`define VOL_SAFE_CODE       8'h24
`define VOL_MUTE_ABOVE      8'hc8
`define VOL_STEPS_PER_6DB   8'd12
`define HYS_UNIT_SAMPLES    16'd16
`define DRAIN_SAMPLES       16'd3
`define DLY_UNIT_CYCLES     16'd8
`define GATE_UNIT_SAMPLES   16'd64
`define LOWPWR_THR_SHIFT    5'd16
`define GATE_THR_SHIFT      5'd12
`define HPF_SHIFT_BASE      4'd3

`endif

// [hdl/pgsc_pkg.sv]
// Types shared by the playback gain and supply control block
package pgsc_pkg;
    typedef enum logic [1:0] {
        MODE_BRIDGE  = 2'b00,
        MODE_RSVD    = 2'b01,
        MODE_HV_ONLY = 2'b10,
        MODE_LOWPWR  = 2'b11
    } supply_mode_t;
    typedef enum logic {SUPPLY_HV, SUPPLY_BAT} bridge_supply_t;
    typedef enum {ST_HV, ST_HYST, ST_DRAIN, ST_BAT, ST_RETURN} switch_state_t;
endpackage

// [hdl/pb_volume_stage.sv]
// Digital volume with ramping, safe attenuation and mute
`timescale 1ns/1ps
`default_nettype none
`include "pgsc_map.svh"
module pb_volume_stage #(
    parameter int W = 24
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Settings
    input  wire logic [7:0]   target_code,
    input  wire logic         safe,
    input  wire logic [1:0]   ramp_rate,
    // Samples
    input  wire logic [W-1:0] din,
    input  wire logic         din_valid,
    output logic [W-1:0]      dout,
    output logic              dout_valid,
    // State
    output logic [7:0]        cur_code
);
    import pgsc_pkg::*;

    logic [7:0]   cur_q, cur_d;
    logic [1:0]   rcnt_q, rcnt_d;
    logic [W-1:0] dout_q;
    logic         dvalid_q;

    // Gain of the 0.5 dB steps inside one 6 dB octave
    function automatic logic [15:0] mant(input logic [3:0] r);
        case (r)
            4'd0:    mant = 16'hffff;
            4'd1:    mant = 16'hf1ae;
            4'd2:    mant = 16'he429;
            4'd3:    mant = 16'hd766;
            4'd4:    mant = 16'hcb59;
            4'd5:    mant = 16'hbff9;
            4'd6:    mant = 16'hb53c;
            4'd7:    mant = 16'hab18;
            4'd8:    mant = 16'ha186;
            4'd9:    mant = 16'h987d;
            4'd10:   mant = 16'h8ff5;
            4'd11:   mant = 16'h87e8;
            default: mant = 16'h0000;
        endcase
    endfunction

    wire         immediate  = safe || (ramp_rate == 2'b11);
    wire [7:0]   eff_target = safe ? `VOL_SAFE_CODE : target_code;
    wire [1:0]   rate_lim   = (ramp_rate == 2'b00) ? 2'd0 : (ramp_rate == 2'b01) ? 2'd1 : 2'd3;
    wire [7:0]   octave     = cur_q / `VOL_STEPS_PER_6DB;
    wire [7:0]   step_in    = cur_q % `VOL_STEPS_PER_6DB;
    wire         mute       = cur_q > `VOL_MUTE_ABOVE;
    wire signed [W+16:0] prod = $signed(din) * $signed({1'b0, mant(step_in[3:0])});
    // Whole octaves need no multiply, so code zero stays exact unity
    wire signed [W-1:0]  unity  = $signed(din) >>> octave[4:0];
    wire signed [W-1:0]  scaled = (step_in == 8'd0) ? unity : W'($signed(prod[W+15:16]) >>> octave[4:0]);

    always_comb begin
        cur_d  = cur_q;
        rcnt_d = rcnt_q;
        if (immediate) begin
            cur_d  = eff_target;
            rcnt_d = 2'd0;
        end else if (din_valid && cur_q != eff_target) begin
            if (rcnt_q >= rate_lim) begin
                rcnt_d = 2'd0;
                cur_d  = (cur_q < eff_target) ? cur_q + 8'd1 : cur_q - 8'd1;
            end else begin
                rcnt_d = rcnt_q + 2'd1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cur_q    <= `VOL_RESET;
            rcnt_q   <= 2'd0;
            dout_q   <= '0;
            dvalid_q <= 1'b0;
        end else begin
            cur_q    <= cur_d;
            rcnt_q   <= rcnt_d;
            dvalid_q <= din_valid;
            if (din_valid) begin
                dout_q <= mute ? '0 : scaled;
            end
        end
    end

    assign dout       = dout_q;
    assign dout_valid = dvalid_q;
    assign cur_code   = cur_q;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_mute_zero_out: assert property (din_valid && cur_q > 8'hc8 |=> dout == '0)
        else $error("muted code let a sample through");
    a_safe_code_set: assert property (safe |=> cur_q == 8'h24)
        else $error("safe attenuation not applied at once");
    a_ramp_off_jump: assert property (ramp_rate == 2'b11 && !safe |=> cur_q == $past(target_code))
        else $error("volume did not jump with ramping off");
    a_ramp_one_step: assert property (ramp_rate != 2'b11 && !safe |=>
        (cur_q == $past(cur_q) || cur_q == $past(cur_q) + 8'd1 || cur_q == $past(cur_q) - 8'd1))
        else $error("ramping volume moved more than one step");
endmodule
`default_nettype wire

// [tb/sample_source.sv]
// Host-side sample source for the playback stream
`timescale 1ns/1ps
`default_nettype none
module sample_source (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Control
    input  wire logic        run,
    input  wire logic [23:0] level,
    // Stream
    output logic [23:0]      sample_in,
    output logic             sample_valid
);
    logic [1:0] gap_q;
    logic       fire;
    assign fire = run && (gap_q == 2'h3);
    // One sample every fourth cycle; idle data never repeats the last value
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gap_q <= 2'h0;
            sample_valid <= 1'b0;
            sample_in <= 24'h0;
        end else begin
            gap_q <= gap_q + 2'h1;
            sample_valid <= fire;
            sample_in <= fire ? level : ~sample_in;
        end
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench of the playback gain and supply block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pgsc_pkg::*;
    logic clk_sys, rst, reg_we, reg_re, run, hv_low, pull, so_v, s_v, oe, pwr, rel_hi, ireg, bout;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [23:0] level, s_in, s_out;
    logic [4:0] amp;
    logic [3:0] rth;
    bridge_supply_t bridge;
    int errors, total_checks;
    sample_source i_src (.clk_sys(clk_sys), .rst(rst), .run(run), .level(level),
        .sample_in(s_in), .sample_valid(s_v));
    playback_gain_supply_control i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .sample_in(s_in), .sample_valid(s_v), .sample_out(s_out), .sample_out_valid(so_v),
        .hv_below_margin(hv_low), .rel_level_above(rel_hi), .amp_output_level(amp),
        .switch_relative_threshold(rth), .internal_regulator_mode(ireg), .bridge_supply(bridge),
        .stage_power_on(pwr), .bypass_enable_in(~(oe | pull)), .bypass_enable_out(bout),
        .bypass_enable_oe(oe));
    task automatic finish_test;
        if (errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_we <= 1'b1; reg_addr <= a; reg_wdata <= v;
        @(posedge clk_sys);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_re <= 1'b1; reg_addr <= a;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_cy(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_reset;
        rd(8'h00); chk(d, 32'h200);
        rd(8'h04); chk(d, 32'h0);
        rd(8'h08); chk(d, 32'h28000);
        rd(8'h1c); chk(d, 32'h0);
        rd(8'h18); chk(d[10:0], 11'h400);
        chk(oe, 1'b1);
        chk(rth, 4'h2);
        chk(bout, 1'b0);
    endtask
    task automatic t_path;
        int n;
        run = 1'b1;
        level = 24'h100000;
        wr(8'h00, 32'h2e0);
        wr(8'h04, 32'h1500); wait_cy(24);
        chk(s_out, 24'h100000);
        chk(amp, 5'h15);
        chk(ireg, 1'b1);
        n = 0;
        repeat (8) begin
            @(posedge clk_sys);
            #1 n += so_v;
        end
        chk(n, 2);
        wr(8'h00, 32'h268); wait_cy(24); chk(s_out, 24'hf00000);
        wr(8'h00, 32'h261); wait_cy(24);
        chk(s_out < 24'h001000, 1'b1);
        wr(8'h00, 32'h260); wr(8'h04, 32'h0c); wait_cy(24); chk(s_out, 24'h080000);
        wr(8'h04, 32'hc9); wait_cy(24); chk(s_out, 24'h0);
        wr(8'h00, 32'h270); rd(8'h18); chk(d[7:0], 8'h24);
        wr(8'h00, 32'h260); wr(8'h04, 32'h0); wait_cy(24);
        wr(8'h00, 32'h200); wr(8'h04, 32'h08); wait_cy(14);
        rd(8'h18); chk(d[7:0] > 8'h0 && d[7:0] < 8'h8, 1'b1);
        wait_cy(60); rd(8'h18); chk(d[7:0], 8'h08);
        wr(8'h04, 32'h0); wr(8'h00, 32'h260); rd(8'h18); chk(d[7:0], 8'h0);
    endtask
    task automatic t_supply(input logic [1:0] m, input logic lo, input logic p, input logic bat, input logic tm);
        @(posedge clk_sys);
        hv_low <= lo;
        pull <= p;
        rel_hi <= 1'b0;
        level <= 24'h0;
        wr(8'h08, {16'h0, tm, 15'h0004}); wr(8'h00, {22'h0, m, 8'h60});
        wait_cy(200);
        chk(bridge, bat ? SUPPLY_BAT : SUPPLY_HV);
        chk(oe, lo | (m == 2'b10));
        @(posedge clk_sys);
        rel_hi <= 1'b1;
        level <= 24'h7fffff;
        wait_cy(40);
        chk(bridge, SUPPLY_HV);
        chk(oe, 1'b1);
        @(posedge clk_sys);
        hv_low <= 1'b0;
        pull <= 1'b0;
        wait_cy(1);
    endtask
    task automatic t_gate;
        level = 24'h0; wr(8'h0c, 32'h1); wait_cy(320);
        chk(pwr, 1'b0);
        level = 24'h7fffff; wait_cy(6);
        chk(pwr, 1'b1);
        wr(8'h10, 32'h100); wr(8'h14, 32'h1);
        level = 24'h0; wr(8'h0c, 32'h41); wait_cy(320);
        chk(pwr, 1'b0);
        level = 24'h000104; wait_cy(12);
        chk(pwr, 1'b0);
        level = 24'h000200; wait_cy(6);
        chk(pwr, 1'b1);
        wr(8'h0c, 32'h0);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #200000 errors++;
        finish_test();
    end
    initial begin
        rst = 1'b1; reg_we = 1'b0; reg_re = 1'b0; reg_addr = 8'h0; reg_wdata = 32'h0;
        run = 1'b0; level = 24'h0; hv_low = 1'b0; pull = 1'b0; rel_hi = 1'b0;
        errors = 0; total_checks = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_path();
        t_supply(2'b00, 1'b0, 1'b0, 1'b1, 1'b0);
        t_supply(2'b11, 1'b0, 1'b0, 1'b1, 1'b0);
        t_supply(2'b10, 1'b0, 1'b0, 1'b0, 1'b0);
        t_supply(2'b00, 1'b1, 1'b0, 1'b0, 1'b0);
        t_supply(2'b00, 1'b0, 1'b1, 1'b0, 1'b0);
        t_supply(2'b00, 1'b0, 1'b0, 1'b1, 1'b1);
        t_gate();
        finish_test();
    end
endmodule
`default_nettype wire
